// file: src/fpc_pkg.sv
`default_nettype none
package fpc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int POR_TIME_US = 100;
	localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
	localparam int INIT_EDGES = 2;

	// ----------------------------------------
	// Image and bus shape
	// ----------------------------------------
	localparam int IMAGE_WORDS_DEF = 256;
	localparam int DATA_W = 32;
	localparam int WORD_W = 16;
	localparam int OPT_INIT_EN_BIT = 0;
	localparam int OPT_USER_IO_BIT = 1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_HOLD = 3'b001,
		ST_READY = 3'b010,
		ST_INIT = 3'b011,
		ST_USER = 3'b100,
		ST_FAULT = 3'b101
	} fpc_state_type;

	typedef struct packed {
		logic user_io;
		logic init_en;
	} fpc_opt_type;

	localparam fpc_opt_type OPT_RESET = '{user_io: 1'b0, init_en: 1'b0};

	// Lane select: x16 uses bits 15..0, x8 uses bits 7..0 only
	function automatic logic [WORD_W-1:0] fpc_lanes(input logic [DATA_W-1:0] d, input logic x16);
		fpc_lanes = x16 ? d[WORD_W-1:0] : {8'h00, d[7:0]};
	endfunction

	// Option bits carried in the first image word
	function automatic fpc_opt_type fpc_opts(input logic [WORD_W-1:0] w);
		fpc_opts = '{user_io: w[OPT_USER_IO_BIT], init_en: w[OPT_INIT_EN_BIT]};
	endfunction

endpackage
`default_nettype wire

// file: src/fpc_config_port.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - One data word is captured on every configuration clock cycle of the transfer.
// - In user mode request, status and load-complete lines all stand high.
// - Low configuration request abandons user mode and restarts configuration.
// - Status held low for the power-on delay after reset, then released once configuration request is high.
// - Load-complete stays low from power-up and through the whole data transfer.
// - x16 samples data bits 15..0; x8 samples only bits 7..0.
// - After configuration the 32 data pins are handed to user logic.
// - Former data pins behave per the dual-purpose option loaded in the image.
// - Load-complete rises only after every image word has been received.
// - Two falling clock edges after load-complete start initialization, then user mode.
// - If enabled, init-done goes low once its option loads, until initialization ends.
// - Configuration clock is ignored once configuration is complete.
module fpc_config_port
	import fpc_pkg::*;
#(
	parameter int IMAGE_WORDS = IMAGE_WORDS_DEF,
	parameter int POR_CNT = POR_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic config_clock,
	input wire logic config_request_n,
	input wire logic status_in,
	output logic status_out,
	output logic status_oe_n,
	output logic load_complete,
	output logic init_done,
	input wire logic mode_x16,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic [DATA_W-1:0] data_oe_n,
	input wire logic [DATA_W-1:0] user_dout,
	input wire logic [DATA_W-1:0] user_oe_n,
	output logic [DATA_W-1:0] user_din,
	output logic user_mode
);

	localparam int PW = $clog2(POR_CNT + 1);
	localparam int CW = $clog2(IMAGE_WORDS + 1);

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	logic arm_s1_r;
	logic arm_s2_r;
	logic x16_s1_r;
	logic x16_s2_r;
	logic arm_r;
	logic [CW-1:0] wcnt_r;
	logic ldone_r;
	logic opt_vld_r;
	fpc_opt_type lopt_r;
	logic [1:0] fe_cnt_r;
	logic go_r;
	logic [WORD_W-1:0] word;
	logic capture;

	assign word = fpc_lanes(data_in, x16_s2_r);
	assign capture = arm_s2_r && !ldone_r;

	// Arm level, dropped at once when the core disarms
	always_ff @(posedge config_clock or negedge arm_r) begin
		if (!arm_r) begin
			arm_s1_r <= 1'b0;
			arm_s2_r <= 1'b0;
		end else begin
			arm_s1_r <= 1'b1;
			arm_s2_r <= arm_s1_r;
		end
	end

	always_ff @(posedge config_clock) begin
		x16_s1_r <= mode_x16;
		x16_s2_r <= x16_s1_r;
	end

	// Word counter, one word per rising edge
	always_ff @(posedge config_clock or negedge arm_s2_r) begin
		if (!arm_s2_r) begin
			wcnt_r <= '0;
			ldone_r <= 1'b0;
		end else if (capture) begin
			wcnt_r <= wcnt_r + CW'(1);
			if (wcnt_r == CW'(IMAGE_WORDS - 1)) begin
				ldone_r <= 1'b1;
			end
		end
	end

	// Options from the first word, kept through user mode
	always_ff @(posedge config_clock) begin
		if (capture && wcnt_r == '0) begin
			lopt_r <= fpc_opts(word);
		end
	end

	always_ff @(posedge config_clock or negedge arm_s2_r) begin
		if (!arm_s2_r) begin
			opt_vld_r <= 1'b0;
		end else if (capture && wcnt_r == '0) begin
			opt_vld_r <= 1'b1;
		end
	end

	// Falling edges after the image; trailing edge of last word counted as the first
	always_ff @(negedge config_clock or negedge arm_s2_r) begin
		if (!arm_s2_r) begin
			fe_cnt_r <= 2'h0;
			go_r <= 1'b0;
		end else if (ldone_r && !go_r) begin
			fe_cnt_r <= fe_cnt_r + 2'h1;
			if (fe_cnt_r == 2'(INIT_EDGES)) begin
				go_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Crossings into the core domain
	// ----------------------------------------
	logic req_s1_r;
	logic req_s2_r;
	logic sts_s1_r;
	logic sts_s2_r;
	logic done_s1_r;
	logic done_s2_r;
	logic go_s1_r;
	logic go_s2_r;
	logic ien_s1_r;
	logic ien_s2_r;
	logic uio_s1_r;
	logic uio_s2_r;
	logic [DATA_W-1:0] din_s1_r;
	logic [DATA_W-1:0] din_s2_r;
	logic rel_d1_r;
	logic rel_d2_r;

	always_ff @(posedge clk) begin
		req_s1_r <= config_request_n;
		req_s2_r <= req_s1_r;
		sts_s1_r <= status_in;
		sts_s2_r <= sts_s1_r;
		done_s1_r <= ldone_r;
		done_s2_r <= done_s1_r;
		go_s1_r <= go_r;
		go_s2_r <= go_s1_r;
		ien_s1_r <= lopt_r.init_en && opt_vld_r;
		ien_s2_r <= ien_s1_r;
		uio_s1_r <= lopt_r.user_io;
		uio_s2_r <= uio_s1_r;
		din_s1_r <= data_in;
		din_s2_r <= din_s1_r;
		rel_d1_r <= status_oe_n;
		rel_d2_r <= rel_d1_r;
	end

	// ----------------------------------------
	// Core state machine
	// ----------------------------------------
	fpc_state_type state_r;
	fpc_state_type state_nxt;
	logic [PW-1:0] por_cnt_r;
	logic uio_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_POR: begin
				if (por_cnt_r == PW'(POR_CNT - 1)) begin
					state_nxt = req_s2_r ? ST_READY : ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (req_s2_r) begin
					state_nxt = ST_READY;
				end
			end
			ST_READY: begin
				if (!req_s2_r) begin
					state_nxt = ST_HOLD;
				end else if (rel_d2_r && !sts_s2_r) begin
					state_nxt = ST_FAULT;
				end else if (done_s2_r) begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT: begin
				if (!req_s2_r) begin
					state_nxt = ST_HOLD;
				end else if (go_s2_r) begin
					state_nxt = ST_USER;
				end
			end
			ST_USER: begin
				if (!req_s2_r) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_FAULT: begin
				if (!req_s2_r) begin
					state_nxt = ST_HOLD;
				end
			end
			default: state_nxt = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= ST_POR;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || state_r != ST_POR) begin
			por_cnt_r <= '0;
		end else begin
			por_cnt_r <= por_cnt_r + PW'(1);
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			status_out <= 1'b0;
			status_oe_n <= 1'b0;
			load_complete <= 1'b0;
			init_done <= 1'b1;
			arm_r <= 1'b0;
			user_mode <= 1'b0;
		end else begin
			status_out <= 1'b0;
			status_oe_n <= state_nxt inside {ST_READY, ST_INIT, ST_USER};
			load_complete <= state_nxt inside {ST_INIT, ST_USER};
			init_done <= !(ien_s2_r && state_nxt inside {ST_READY, ST_INIT});
			arm_r <= state_nxt inside {ST_READY, ST_INIT};
			user_mode <= state_nxt == ST_USER;
		end
	end

	// Data pins handed to user logic
	always_ff @(posedge clk) begin
		if (!rstn) begin
			uio_r <= 1'b0;
			data_out <= '0;
			data_oe_n <= '1;
			user_din <= '0;
		end else begin
			uio_r <= state_nxt == ST_USER && uio_s2_r;
			data_out <= uio_r ? user_dout : '0;
			data_oe_n <= uio_r ? user_oe_n : '1;
			user_din <= state_r == ST_USER ? din_s2_r : '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	int por_span_r;
	logic por_seen_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			por_span_r <= 0;
			por_seen_r <= 1'b0;
		end else begin
			if (!status_oe_n) begin
				por_span_r <= por_span_r + 1;
			end
			if (status_oe_n) begin
				por_seen_r <= 1'b1;
			end
		end
	end

	user_lines_a: assert property (state_r == ST_USER |-> status_oe_n && load_complete)
		else $error("user mode lines not high");
	reconfig_a: assert property (!req_s2_r && state_r != ST_POR |=> state_r == ST_HOLD)
		else $error("request low did not restart");
	por_delay_a: assert property ($rose(status_oe_n) && !por_seen_r |-> por_span_r >= POR_CNT)
		else $error("status released before power-on delay");
	lc_low_a: assert property (state_r inside {ST_POR, ST_HOLD, ST_READY} |-> !load_complete)
		else $error("load complete high during transfer");
	lc_rise_a: assert property ($rose(load_complete) |-> $past(done_s2_r))
		else $error("load complete without full image");
	init_edges_a: assert property ($rose(user_mode) |-> $past(go_s2_r))
		else $error("user mode before init edges");
	init_low_a: assert property (state_r == ST_INIT && ien_s2_r |-> !init_done)
		else $error("init done not held low");
	pins_held_a: assert property (state_r != ST_USER |=> data_oe_n == '1)
		else $error("data pins driven during configuration");
	pins_opt_a: assert property (state_r == ST_USER && !uio_s2_r ##1 state_r == ST_USER |=> data_oe_n == '1)
		else $error("pins driven without user option");

	one_word_a: assert property (@(posedge config_clock) disable iff (!arm_s2_r)
		capture |=> wcnt_r == $past(wcnt_r) + CW'(1))
		else $error("word not counted");
	lane8_a: assert property (@(posedge config_clock) disable iff (!arm_s2_r)
		!x16_s2_r |-> word[WORD_W-1:8] == 8'h00)
		else $error("upper lanes sampled in x8");
	frozen_a: assert property (@(posedge config_clock) disable iff (!arm_s2_r)
		ldone_r |=> $stable(wcnt_r) && ldone_r)
		else $error("clock not ignored after image");

	user_entry_c: cover property ($rose(user_mode));
	reconfig_c: cover property (state_r == ST_USER ##1 state_r == ST_HOLD);
	init_en_c: cover property (!init_done ##1 init_done && user_mode);
	fault_c: cover property (state_r == ST_FAULT);

endmodule // fpc_config_port
`default_nettype wire

// file: dv/fpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model
	import fpc_pkg::*;
(
	output logic config_clock,
	output logic [DATA_W-1:0] data_in
);
	// ----------------------------------------
	// Host side of the link
	// ----------------------------------------
	initial begin
		config_clock = 1'b0;
		data_in = '0;
	end
	// Clock stands low between frames
	task automatic pulse(input int n);
		repeat (n) begin
			#15 config_clock = 1'b1;
			#15 config_clock = 1'b0;
		end
	endtask
	// Two lead-in edges, then one word per cycle; upper lanes inverted with each word
	task automatic send(input logic [WORD_W-1:0] w0, input int nwords);
		pulse(2);
		for (int i = 0; i < nwords; i++) begin
			data_in = {~data_in[31:16], (i == 0) ? w0 : WORD_W'(i)};
			pulse(1);
		end
		data_in = ~data_in;
	endtask
endmodule // fpc_host_model
`default_nettype wire

// file: dv/fast_parallel_config_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fast_parallel_config_port_tb_top
	import fpc_pkg::*;
;
	localparam int IMG = 8;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic config_request_n = 1'b1;
	logic mode_x16 = 1'b1;
	logic [DATA_W-1:0] user_dout = 32'h1234abcd;
	logic [DATA_W-1:0] user_oe_n = 32'h0000ffff;
	wire logic config_clock, status_out, status_oe_n, load_complete, init_done, user_mode;
	wire logic [DATA_W-1:0] data_in, data_out, data_oe_n, user_din;
	wire logic status_in = status_oe_n ? 1'b1 : status_out;
	int failures = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	fpc_host_model host_u (.config_clock(config_clock), .data_in(data_in));
	fpc_config_port #(.IMAGE_WORDS(IMG), .POR_CNT(20)) dut_u (
		.clk(clk), .rstn(rstn), .config_clock(config_clock),
		.config_request_n(config_request_n), .status_in(status_in),
		.status_out(status_out), .status_oe_n(status_oe_n),
		.load_complete(load_complete), .init_done(init_done), .mode_x16(mode_x16),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.user_dout(user_dout), .user_oe_n(user_oe_n), .user_din(user_din),
		.user_mode(user_mode)
	);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Full image, two init edges, then user-mode pin handover
	task automatic load(input logic x16, input logic [WORD_W-1:0] w0, input logic ie,
			input logic ue);
		mode_x16 = x16;
		fork
			host_u.send(w0, IMG);
			begin
				tick(2);
				check(load_complete, 1'b0);
			end
		join
		for (int i = 0; i < 10 && load_complete !== 1'b1; i++) tick(1);
		check(load_complete, 1'b1);
		check(init_done, !ie);
		check(user_mode, 1'b0);
		host_u.pulse(2);
		for (int i = 0; i < 10 && user_mode !== 1'b1; i++) tick(1);
		tick(3);
		check({user_mode, init_done, load_complete, status_in}, 4'hf);
		check(data_oe_n, ue ? user_oe_n : '1);
		check(data_out, ue ? user_dout : '0);
		check(user_din, data_in);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_por();
		tick(10);
		check({status_oe_n, load_complete, init_done}, 3'b001);
		tick(20);
		check(status_in, 1'b1);
		$display("test_por done");
	endtask
	task automatic test_short();
		mode_x16 = 1'b0;
		host_u.send(16'hfc03, IMG - 1);
		tick(10);
		check(load_complete, 1'b0);
		config_request_n = 1'b0;
		tick(5);
		config_request_n = 1'b1;
		tick(5);
		$display("test_short done");
	endtask
	task automatic test_x16();
		load(1'b1, 16'h0003, 1'b1, 1'b1);
		host_u.pulse(4);
		tick(4);
		check({user_mode, load_complete}, 2'b11);
		check(data_oe_n, user_oe_n);
		$display("test_x16 done");
	endtask
	task automatic test_reconfig();
		config_request_n = 1'b0;
		tick(4);
		check({status_oe_n, load_complete, user_mode, init_done}, 4'b0001);
		check(data_oe_n, '1);
		config_request_n = 1'b1;
		tick(5);
		check(status_in, 1'b1);
		$display("test_reconfig done");
	endtask
	task automatic test_x8();
		load(1'b0, 16'hfc03, 1'b1, 1'b1);
		$display("test_x8 done");
	endtask
	task automatic test_noopt();
		load(1'b1, 16'hfffc, 1'b0, 1'b0);
		$display("test_noopt done");
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		tick(12);
		rstn = 1'b1;
		test_por();
		test_short();
		test_x16();
		test_reconfig();
		test_x8();
		test_reconfig();
		test_noopt();
		final_report();
	end
	initial begin
		#200000;
		failures++;
		final_report();
	end
endmodule // fast_parallel_config_port_tb_top
`default_nettype wire
